// ### core/apg_aux_pulse_gen.sv
// Functional notes
// - Zero offset is signed degrees from absolute zero to the first reference.
// - Absolute zero comes from the selected crank pattern type.
// - Each cylinder reference is a degree offset from the first one.
// - Each channel picks its reference cylinder through its own selector.
// - Channels run independently and re-arm once per engine cycle.
// - Two-stroke span is 360 degrees, plus or minus 180 around reference.
// - Four-stroke span is 720 degrees, plus or minus 360 around reference.
// - Window open and close are degrees before the channel reference.
// - Eight channels, each with enables, reference selection and timing.
// - Output is driven only while the channel enable is set.
// - A pulse starts only while the pulse enable is set; clearing it does not end a pulse already high.
// - Sync angle, degrees before reference, starts the pulse timing.
// - Pulse starts the set number of milliseconds after the sync angle.
// - Pulse stays high for the set milliseconds, then returns low.
//
// Design decisions made here: the Wishbone register port and the register addresses.
module apg_aux_pulse_gen #(
    parameter int CYC_PER_MS = apg_pkg::CYC_PER_MS // Clock cycles in one millisecond
) (
    input wire logic clk_i, // 100 MHz clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes all state when low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic [9:0] crank_pos_i, // Crank tracker position, same clock
    input wire logic crank_valid_i, // Crank tracker position valid
    output logic [7:0] aux_pulse_o, // TTL pulse per channel
    output logic [7:0] aux_oe_o // Output enable per channel
);
    localparam int NCH = apg_pkg::NUM_CH;
    localparam int NCYL = apg_pkg::NUM_CYL;

    logic four_ff, nxt_four;
    logic [1:0] pat_ff, nxt_pat;
    apg_pkg::apg_ang_t zoff_ff, nxt_zoff;
    logic [7:0] chen_ff, nxt_chen;
    logic [7:0] pen_ff, nxt_pen;
    apg_pkg::apg_ang_t cyl_ff [NCYL];
    apg_pkg::apg_ang_t nxt_cyl [NCYL];
    apg_pkg::apg_sel_t rsel_ff [NCH];
    apg_pkg::apg_sel_t nxt_rsel [NCH];
    apg_pkg::apg_ang_t wopen_ff [NCH];
    apg_pkg::apg_ang_t nxt_wopen [NCH];
    apg_pkg::apg_ang_t wclose_ff [NCH];
    apg_pkg::apg_ang_t nxt_wclose [NCH];
    apg_pkg::apg_ang_t sync_ff [NCH];
    apg_pkg::apg_ang_t nxt_sync [NCH];
    apg_pkg::apg_ms_t dly_ff [NCH];
    apg_pkg::apg_ms_t nxt_dly [NCH];
    apg_pkg::apg_ms_t wid_ff [NCH];
    apg_pkg::apg_ms_t nxt_wid [NCH];
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    apg_pkg::apg_sang_t dbr_prev_ff [NCH];
    apg_pkg::apg_sang_t nxt_dbr_prev [NCH];
    logic valid_prev_ff, nxt_valid_prev;

    logic [7:0] wa;
    logic [31:0] rd_val;
    logic [31:0] wdat;
    logic wr_go;
    logic [2:0] ch_idx;
    logic [3:0] cyl_idx;
    apg_pkg::apg_sang_t span;
    apg_pkg::apg_sang_t pos;
    apg_pkg::apg_sang_t dbr [NCH];
    logic [7:0] in_win;
    logic evt_ok;

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : wb_merge

    function automatic apg_pkg::apg_cnt_t ms_to_cyc(input apg_pkg::apg_ms_t ms);
        return apg_pkg::apg_cnt_t'(32'(ms) * CYC_PER_MS);
    endfunction : ms_to_cyc

    assign wa = {wb_adr_i[7:2], 2'b00};
    assign ch_idx = wa[6:4];
    assign cyl_idx = wa[5:2];
    // Write lands on the edge at which the master samples ack
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (wa == apg_pkg::REG_CTRL) begin
            rd_val[apg_pkg::CTRL_FOUR_BIT] = four_ff;
            rd_val[apg_pkg::CTRL_PAT_LSB +: 2] = pat_ff;
        end else if (wa == apg_pkg::REG_ZERO) begin
            rd_val[11:0] = zoff_ff;
        end else if (wa == apg_pkg::REG_CHEN) begin
            rd_val[7:0] = chen_ff;
            rd_val[apg_pkg::CHEN_PULSE_LSB +: 8] = pen_ff;
        end else if (wa == apg_pkg::REG_STAT) begin
            rd_val[7:0] = aux_pulse_o;
            rd_val[apg_pkg::STAT_WIN_LSB +: 8] = in_win;
            rd_val[apg_pkg::STAT_POS_LSB +: 12] = pos[11:0];
        end else if (wa >= apg_pkg::REG_CYL_BASE && wa <= apg_pkg::REG_CYL_LAST) begin
            rd_val[11:0] = cyl_ff[cyl_idx];
        end else if (wa >= apg_pkg::REG_CH_BASE) begin
            if (wa[3:2] == apg_pkg::CH_SUB_REF) begin
                rd_val[3:0] = rsel_ff[ch_idx];
            end else if (wa[3:2] == apg_pkg::CH_SUB_WIN) begin
                rd_val[11:0] = wopen_ff[ch_idx];
                rd_val[apg_pkg::WIN_CLOSE_LSB +: 12] = wclose_ff[ch_idx];
            end else if (wa[3:2] == apg_pkg::CH_SUB_SYNC) begin
                rd_val[11:0] = sync_ff[ch_idx];
            end else begin
                rd_val[7:0] = dly_ff[ch_idx];
                rd_val[apg_pkg::TIME_WID_LSB +: 8] = wid_ff[ch_idx];
            end
        end
    end

    always_comb begin
        nxt_four = four_ff;
        nxt_pat = pat_ff;
        nxt_zoff = zoff_ff;
        nxt_chen = chen_ff;
        nxt_pen = pen_ff;
        nxt_cyl = cyl_ff;
        nxt_rsel = rsel_ff;
        nxt_wopen = wopen_ff;
        nxt_wclose = wclose_ff;
        nxt_sync = sync_ff;
        nxt_dly = dly_ff;
        nxt_wid = wid_ff;
        nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
        nxt_rdat = nxt_ack ? rd_val : rdat_ff;
        wdat = wb_merge(rd_val, wb_dat_i, wb_sel_i);
        if (wr_go) begin
            if (wa == apg_pkg::REG_CTRL) begin
                nxt_four = wdat[apg_pkg::CTRL_FOUR_BIT];
                nxt_pat = wdat[apg_pkg::CTRL_PAT_LSB +: 2];
            end else if (wa == apg_pkg::REG_ZERO) begin
                nxt_zoff = wdat[11:0];
            end else if (wa == apg_pkg::REG_CHEN) begin
                nxt_chen = wdat[7:0];
                nxt_pen = wdat[apg_pkg::CHEN_PULSE_LSB +: 8];
            end else if (wa >= apg_pkg::REG_CYL_BASE && wa <= apg_pkg::REG_CYL_LAST) begin
                nxt_cyl[cyl_idx] = wdat[11:0];
            end else if (wa >= apg_pkg::REG_CH_BASE) begin
                if (wa[3:2] == apg_pkg::CH_SUB_REF) begin
                    nxt_rsel[ch_idx] = wdat[3:0];
                end else if (wa[3:2] == apg_pkg::CH_SUB_WIN) begin
                    nxt_wopen[ch_idx] = wdat[11:0];
                    nxt_wclose[ch_idx] = wdat[apg_pkg::WIN_CLOSE_LSB +: 12];
                end else if (wa[3:2] == apg_pkg::CH_SUB_SYNC) begin
                    nxt_sync[ch_idx] = wdat[11:0];
                end else begin
                    nxt_dly[ch_idx] = wdat[7:0];
                    nxt_wid[ch_idx] = wdat[apg_pkg::TIME_WID_LSB +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            four_ff <= apg_pkg::RST_FOUR;
            pat_ff <= apg_pkg::RST_PAT;
            zoff_ff <= apg_pkg::RST_ZOFF;
            chen_ff <= apg_pkg::RST_CHEN;
            pen_ff <= apg_pkg::RST_CHEN;
            cyl_ff <= apg_pkg::CYL_REF_RST;
            for (int i = 0; i < NCH; i++) begin
                rsel_ff[i] <= apg_pkg::RST_SEL;
                wopen_ff[i] <= apg_pkg::RST_WOPEN;
                wclose_ff[i] <= apg_pkg::RST_WCLOSE;
                sync_ff[i] <= apg_pkg::RST_SYNC;
                dly_ff[i] <= apg_pkg::RST_MS;
                wid_ff[i] <= apg_pkg::RST_MS;
            end
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            four_ff <= nxt_four;
            pat_ff <= nxt_pat;
            zoff_ff <= nxt_zoff;
            chen_ff <= nxt_chen;
            pen_ff <= nxt_pen;
            cyl_ff <= nxt_cyl;
            rsel_ff <= nxt_rsel;
            wopen_ff <= nxt_wopen;
            wclose_ff <= nxt_wclose;
            sync_ff <= nxt_sync;
            dly_ff <= nxt_dly;
            wid_ff <= nxt_wid;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign aux_oe_o = chen_ff;

    // Engine cycle span from stroke setting
    assign span = four_ff ? apg_pkg::SPAN_FOUR_STROKE : apg_pkg::SPAN_TWO_STROKE;
    assign pos = apg_pkg::apg_wrap(
        apg_pkg::apg_sang_t'(crank_pos_i / apg_pkg::TRK_CNT_PER_DEG)
        - apg_pkg::apg_sang_t'(apg_pkg::PAT_ZERO[pat_ff]) - apg_pkg::apg_sx(zoff_ff), span);
    assign evt_ok = crank_valid_i && valid_prev_ff;

    apg_ch_if ch_if [NCH] ();

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        apg_pkg::apg_sang_t ref_ang;
        apg_pkg::apg_sang_t open_ang;
        apg_pkg::apg_sang_t close_ang;
        apg_pkg::apg_sang_t sync_ang;

        assign ref_ang = apg_pkg::apg_sx(rsel_ff[g] < NCYL ? cyl_ff[rsel_ff[g]] : cyl_ff[0]);
        assign dbr[g] = apg_pkg::apg_dbr(apg_pkg::apg_wrap(pos - ref_ang, span), span);
        assign open_ang = apg_pkg::apg_sx(wopen_ff[g]);
        assign close_ang = apg_pkg::apg_sx(wclose_ff[g]);
        assign sync_ang = apg_pkg::apg_sx(sync_ff[g]);
        // Window bounds in degrees before reference
        assign in_win[g] = (dbr[g] <= open_ang) && (dbr[g] >= close_ang);
        assign ch_if[g].in_window = in_win[g];
        // Non-overlapping windows give one entry per cycle
        assign ch_if[g].win_enter = evt_ok && apg_pkg::apg_crossed(dbr_prev_ff[g], dbr[g],
                                                                  open_ang);
        assign ch_if[g].sync_hit = evt_ok && apg_pkg::apg_crossed(dbr_prev_ff[g], dbr[g],
                                                                 sync_ang);
        assign ch_if[g].ch_en = chen_ff[g];
        assign ch_if[g].pulse_en = pen_ff[g];
        assign ch_if[g].dly_cyc = ms_to_cyc(dly_ff[g]);
        assign ch_if[g].wid_cyc = ms_to_cyc(wid_ff[g]);
        assign aux_pulse_o[g] = ch_if[g].pulse;

        apg_chan u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .cif(ch_if[g].chan)
        );

        a_span_bound: assert property (@(posedge clk_i) disable iff (rst_i)
            (dbr[g] < (span >>> 1)) && (dbr[g] >= -(span >>> 1)))
            else $error("Angle before reference outside the cycle span");
    end

    always_comb begin
        nxt_dbr_prev = dbr;
        nxt_valid_prev = crank_valid_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                dbr_prev_ff[i] <= '0;
            end
            valid_prev_ff <= 1'b0;
        end else if (ce_i) begin
            dbr_prev_ff <= nxt_dbr_prev;
            valid_prev_ff <= nxt_valid_prev;
        end
    end

    a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !ack_ff && ce_i |=> wb_ack_o)
        else $error("Bus request not acknowledged after one cycle");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle");
    a_oe_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_go && (wa == apg_pkg::REG_CHEN) && wb_sel_i[0]
        |=> aux_oe_o == $past(wb_dat_i[7:0]))
        else $error("Output enable does not follow the channel enable write");

    c_bus_write: cover property (@(posedge clk_i) wb_ack_o && wb_we_i);
endmodule : apg_aux_pulse_gen

// ### core/apg_pkg.sv
package apg_pkg;
    localparam int NUM_CH = 8;
    localparam int NUM_CYL = 12;
    localparam int CNT_W = 26;
    localparam int MS_W = 8;

    typedef logic [11:0] apg_ang_t;
    typedef logic signed [12:0] apg_sang_t;
    typedef logic [CNT_W-1:0] apg_cnt_t;
    typedef logic [MS_W-1:0] apg_ms_t;
    typedef logic [3:0] apg_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b10,
        ST_PULSE = 2'b11
    } apg_state_t;

    // Timing: one millisecond at a 10 ns clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_UNIT_MS = 1;
    localparam int CYC_PER_MS = (PULSE_UNIT_MS * 1_000_000) / CLK_PERIOD_NS;
    localparam int TRK_CNT_PER_DEG = 1;
    localparam apg_cnt_t CNT_ONE = 26'h000_0001;
    localparam apg_sang_t SPAN_TWO_STROKE = 13'h0168;
    localparam apg_sang_t SPAN_FOUR_STROKE = 13'h02d0;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ZERO = 8'h04;
    localparam logic [7:0] REG_CHEN = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_CYL_BASE = 8'h40;
    localparam logic [7:0] REG_CYL_LAST = 8'h6c;
    localparam logic [7:0] REG_CH_BASE = 8'h80;
    localparam logic [1:0] CH_SUB_REF = 2'h0;
    localparam logic [1:0] CH_SUB_WIN = 2'h1;
    localparam logic [1:0] CH_SUB_SYNC = 2'h2;
    localparam logic [1:0] CH_SUB_TIME = 2'h3;

    // Field positions
    localparam int CTRL_FOUR_BIT = 0;
    localparam int CTRL_PAT_LSB = 1;
    localparam int CHEN_PULSE_LSB = 8;
    localparam int WIN_CLOSE_LSB = 16;
    localparam int TIME_WID_LSB = 8;
    localparam int STAT_WIN_LSB = 8;
    localparam int STAT_POS_LSB = 16;

    // Values after reset
    localparam logic RST_FOUR = 1'b1;
    localparam logic [1:0] RST_PAT = 2'h0;
    localparam apg_ang_t RST_ZOFF = 12'h000;
    localparam logic [7:0] RST_CHEN = 8'h00;
    localparam apg_sel_t RST_SEL = 4'h0;
    localparam apg_ang_t RST_WOPEN = 12'h167;
    localparam apg_ang_t RST_WCLOSE = 12'he99;
    localparam apg_ang_t RST_SYNC = 12'h000;
    localparam apg_ms_t RST_MS = 8'h00;
    localparam apg_ang_t CYL_REF_RST [NUM_CYL] = '{
        12'h000, 12'h0f0, 12'h1e0, 12'h03c, 12'h12c, 12'h21c,
        12'h078, 12'h168, 12'h258, 12'h0b4, 12'h1a4, 12'h294
    };
    // Degrees of absolute zero for each crank pattern type
    localparam logic [9:0] PAT_ZERO [4] = '{10'h000, 10'h05a, 10'h0b4, 10'h10e};

    function automatic apg_sang_t apg_sx(input apg_ang_t a);
        return {a[11], a};
    endfunction : apg_sx

    function automatic apg_sang_t apg_wrap(input apg_sang_t a, input apg_sang_t span);
        apg_sang_t r;
        r = a;
        for (int i = 0; i < 12; i++) begin
            if (r < 0) begin
                r = r + span;
            end else if (r >= span) begin
                r = r - span;
            end
        end
        return r;
    endfunction : apg_wrap

    // Position after the reference becomes degrees before it, centred on the span
    function automatic apg_sang_t apg_dbr(input apg_sang_t rel, input apg_sang_t span);
        if (rel <= (span >>> 1)) begin
            return -rel;
        end
        return span - rel;
    endfunction : apg_dbr

    // Crank advances towards smaller degrees-before; a rise means the span wrapped
    function automatic logic apg_crossed(input apg_sang_t prev, input apg_sang_t cur,
                                         input apg_sang_t ang);
        return ((prev > ang) || (prev < cur)) && (cur <= ang);
    endfunction : apg_crossed
endpackage : apg_pkg

// ### core/apg_ch_if.sv
interface apg_ch_if;
    logic ch_en;
    logic pulse_en;
    logic sync_hit;
    logic win_enter;
    logic in_window;
    apg_pkg::apg_cnt_t dly_cyc;
    apg_pkg::apg_cnt_t wid_cyc;
    logic pulse;

    modport top (
        output ch_en, pulse_en, sync_hit, win_enter, in_window, dly_cyc, wid_cyc,
        input pulse
    );
    modport chan (
        input ch_en, pulse_en, sync_hit, win_enter, in_window, dly_cyc, wid_cyc,
        output pulse
    );
endinterface : apg_ch_if

// ### core/apg_chan.sv
module apg_chan (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable
    apg_ch_if.chan cif // Channel controls and crank events
);
    apg_pkg::apg_state_t state_ff, nxt_state;
    apg_pkg::apg_cnt_t cnt_ff, nxt_cnt;
    apg_pkg::apg_cnt_t hi_cnt_ff, nxt_hi_cnt;
    logic pulse_ff, nxt_pulse;
    logic go;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        go = 1'b0;
        case (state_ff)
            apg_pkg::ST_IDLE: begin
                nxt_state = apg_pkg::ST_IDLE;
            end
            apg_pkg::ST_ARMED: begin
                if (cif.sync_hit) begin
                    if (cif.in_window && cif.pulse_en) begin
                        if (cif.dly_cyc == '0) begin
                            go = 1'b1;
                        end else begin
                            nxt_state = apg_pkg::ST_DELAY;
                            nxt_cnt = cif.dly_cyc - apg_pkg::CNT_ONE;
                        end
                    end else begin
                        nxt_state = apg_pkg::ST_IDLE;
                    end
                end
            end
            apg_pkg::ST_DELAY: begin
                if (cnt_ff == '0) begin
                    if (cif.in_window && cif.pulse_en) begin
                        go = 1'b1;
                    end else begin
                        nxt_state = apg_pkg::ST_IDLE;
                    end
                end else begin
                    nxt_cnt = cnt_ff - apg_pkg::CNT_ONE;
                end
            end
            apg_pkg::ST_PULSE: begin
                if (cnt_ff == '0) begin
                    nxt_state = apg_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - apg_pkg::CNT_ONE;
                end
            end
            default: begin
                nxt_state = apg_pkg::ST_IDLE;
            end
        endcase
        if (go) begin
            if (cif.wid_cyc != '0) begin
                nxt_state = apg_pkg::ST_PULSE;
                nxt_cnt = cif.wid_cyc - apg_pkg::CNT_ONE;
            end else begin
                nxt_state = apg_pkg::ST_IDLE;
            end
        end
        if (cif.win_enter) begin
            nxt_state = apg_pkg::ST_ARMED;
            nxt_cnt = '0;
        end
        if (!cif.ch_en) begin
            nxt_state = apg_pkg::ST_IDLE;
        end
        nxt_pulse = (nxt_state == apg_pkg::ST_PULSE);
        nxt_hi_cnt = pulse_ff ? hi_cnt_ff + apg_pkg::CNT_ONE : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= apg_pkg::ST_IDLE;
            cnt_ff <= '0;
            pulse_ff <= 1'b0;
            hi_cnt_ff <= '0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end

    assign cif.pulse = pulse_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_off_disabled: assert property (ce_i && !cif.ch_en |=> !pulse_ff)
        else $error("Pulse active on a disabled channel");
    a_start_window: assert property ($rose(pulse_ff) |-> $past(cif.in_window))
        else $error("Pulse started outside the firing window");
    a_start_enable: assert property ($rose(pulse_ff) |-> $past(cif.pulse_en && cif.ch_en))
        else $error("Pulse started without pulse enable");
    a_width_exact: assert property ((state_ff == apg_pkg::ST_PULSE) && (cnt_ff == '0) && ce_i
        && cif.ch_en && !cif.win_enter |-> (hi_cnt_ff + apg_pkg::CNT_ONE == cif.wid_cyc))
        else $error("Pulse length differs from the set duration");
    a_delay_start: assert property ((state_ff == apg_pkg::ST_DELAY) && (cnt_ff == '0) && ce_i
        && cif.ch_en && cif.in_window && cif.pulse_en && !cif.win_enter
        && (cif.wid_cyc != '0) |=> pulse_ff ##1 (pulse_ff || !$past(ce_i) || !cif.ch_en
        || (cif.wid_cyc == apg_pkg::CNT_ONE)))
        else $error("Pulse did not start when the delay expired");
    a_rearm_window: assert property (ce_i && cif.ch_en && cif.win_enter
        |=> state_ff == apg_pkg::ST_ARMED)
        else $error("Channel not re-armed on window entry");

    c_pulse_fired: cover property ($rose(pulse_ff));
    c_suppressed: cover property ((state_ff == apg_pkg::ST_DELAY) && (cnt_ff == '0) && ce_i
        && cif.ch_en && !cif.in_window);
endmodule : apg_chan

// ### verif/apg_trig_model.sv
module apg_trig_model (
    input wire logic clk_i, // Clock
    input wire logic [7:0] trig_i, // Trigger inputs
    input wire logic [7:0] oe_i // Pin driven when high
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int n_rise [8];
    int width [8];
    int rise_at [8];
    logic [7:0] prev = 8'h00;
    logic [7:0] lvl;
    assign lvl = trig_i & oe_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        prev <= lvl;
        for (int i = 0; i < 8; i++) begin
            if (lvl[i] && !prev[i]) begin
                n_rise[i] <= n_rise[i] + 1;
                rise_at[i] <= cyc;
                width[i] <= 1;
            end else if (lvl[i]) begin
                width[i] <= width[i] + 1;
            end
        end
    end
endmodule : apg_trig_model

// ### verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0;
    logic we = 1'h0;
    logic ack;
    logic [7:0] adr = 8'h00;
    logic [7:0] pulse;
    logic [7:0] oe;
    logic [9:0] crank = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    int n_mismatch = 0;
    int comparisons = 0;
    int t0 = 0;
    int t5 = 0;
    always #5 clk_i = ~clk_i;
    apg_aux_pulse_gen #(.CYC_PER_MS(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .crank_pos_i(crank),
        .crank_valid_i(!rst_i), .aux_pulse_o(pulse), .aux_oe_o(oe));
    apg_trig_model partner_u (.clk_i(clk_i), .trig_i(pulse), .oe_i(oe));
    task automatic stop_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            stop_test();
        end
        rdat = dat_o;
        cyc <= 1'h0;
        @(posedge clk_i);
    endtask : wb
    // One engine cycle of crank steps, one degree per clock
    task automatic sweep();
        for (int i = 0; i < 720; i++) begin
            crank <= 10'((355 + i) % 720);
            if ((355 + i) % 720 == 0) t0 = partner_u.cyc;
            if ((355 + i) % 720 == 240) t5 = partner_u.cyc;
            @(posedge clk_i);
        end
        repeat (20) @(posedge clk_i);
    endtask : sweep
    task automatic pos_case(input logic [31:0] ctl, input logic [31:0] zo, input int p, input int e);
        wb(1'h1, 8'h04, zo);
        wb(1'h1, 8'h00, ctl);
        crank <= 10'(p);
        repeat (4) @(posedge clk_i);
        wb(1'h0, 8'h0c, 32'h0000_0000);
        check("position", (rdat >> 16) & 32'h0000_0fff, 32'(e));
    endtask : pos_case
    task automatic reset_case();
        wb(1'h0, 8'h00, 32'h0000_0000);
        check("ctrl", rdat, 32'h0000_0001);
        wb(1'h0, 8'h44, 32'h0000_0000);
        check("cyl ref 2", rdat, 32'h0000_00f0);
        wb(1'h0, 8'h84, 32'h0000_0000);
        check("window", rdat, 32'h0e99_0167);
        wb(1'h0, 8'h20, 32'h0000_0000);
        check("unmapped", rdat, 32'h0000_0000);
    endtask : reset_case
    // Ch1 normal, ch2 no pulse enable, ch3 off, ch4 narrow window, ch5 on ref 2
    task automatic channel_case();
        wb(1'h1, 8'h8c, 32'h0000_0201);
        wb(1'h1, 8'hb4, 32'h000a_0167);
        wb(1'h1, 8'hc0, 32'h0000_0001);
        wb(1'h1, 8'hcc, 32'h0000_0100);
        wb(1'h1, 8'h08, 32'h0000_1d1b);
        check("oe", 32'(oe), 32'h0000_001b);
        repeat (2) sweep();
        check("ch1 count", partner_u.n_rise[0], 2);
        check("ch2 count", partner_u.n_rise[1], 0);
        check("ch3 count", partner_u.n_rise[2], 0);
        check("ch4 count", partner_u.n_rise[3], 0);
        check("ch5 count", partner_u.n_rise[4], 2);
        check("ch1 width", partner_u.width[0], 8);
        check("ch5 width", partner_u.width[4], 4);
        // Crank sampling and the registered output add two cycles to the set delay
        check("ch1 delay", partner_u.rise_at[0] - t0, 6);
        check("ch5 delay", partner_u.rise_at[4] - t5, 2);
    endtask : channel_case
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        reset_case();
        channel_case();
        pos_case(32'h0000_0003, 32'h0000_0ff6, 100, 20);
        pos_case(32'h0000_0000, 32'h0000_0000, 400, 40);
        stop_test();
    end
endmodule : testbench
